// >>> verilog/psm_monitor.sv
// Contract
// [RULE_01] every quantity has a warning level with response and a fault level
// [RULE_02] overcurrent warns and limits current, then trips with overcurrent fault
// [RULE_03] dc link overvoltage warns and limits voltage, then trips with fault
// [RULE_04] shutdown thresholds are fixed constants, not user settable
// [RULE_05] warning levels are settable; defaults sit below the shutdown levels
// [RULE_06] heatsink temperature is monitored all the time
// [RULE_07] utilization above 100 percent flags load-integral overload
// [RULE_08] response select: 0 fout, 1 trip, 2 fpulse and fout, 3 fpulse then trip
// [RULE_09] thermal overload raises its warning before any shutdown
// [RULE_10] thermal warning levels are margins below the fixed shutdown values
// [RULE_11] heatsink warning by default 15 degrees below shutdown
// [RULE_12] selected response starts in the same cycle as the thermal warning
// [RULE_13] trip-only keeps operating point; trips only at shutdown level
// [RULE_14] fan failure seen only through heatsink temperature rise
// [RULE_15] open or shorted temperature sensor is a monitored fault
// [RULE_16] warnings drop below threshold; faults latch until acknowledged
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module psm_monitor
  import psm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] output_current_i,
  input wire logic [15:0] dc_link_voltage_i,
  input wire logic [7:0] heatsink_temperature_i,
  input wire logic [7:0] inverter_utilization_i,
  input wire logic [11:0] temp_sensor_code_i,
  output logic overcurrent_warning_o,
  output logic overvoltage_warning_o,
  output logic heatsink_overtemp_warning_o,
  output logic load_integral_warning_o,
  output logic overcurrent_fault_o,
  output logic overvoltage_fault_o,
  output logic overtemperature_fault_o,
  output logic sensor_fault_o,
  output logic current_limit_o,
  output logic vdc_limit_o,
  output logic reduce_output_freq_o,
  output logic reduce_pulse_freq_o,
  output logic trip_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] resp_sel;
    logic [15:0] cur_warn;
    logic [15:0] vdc_warn;
    logic [7:0] hs_margin;
    logic [7:0] li_margin;
    logic oc_warn;
    logic ov_warn;
    logic hs_warn;
    logic li_warn;
    logic oc_fault;
    logic ov_fault;
    logic ot_fault;
    logic sens_fault;
    logic cur_lim;
    logic vdc_lim;
    logic red_fout;
    logic red_fpulse;
    logic trip;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } psm_state_t;

  psm_state_t state_reg;
  psm_state_t state_next;

  // ==========================================================
  // helpers
  function automatic logic [7:0] sat_sub8(input logic [7:0] a, input logic [7:0] b);
    sat_sub8 = (a > b) ? (a - b) : 8'h00;
  endfunction

  // a warning level written at or above the fixed trip is pulled back to one below it
  function automatic logic [15:0] clamp_warn(input logic [15:0] v, input logic [15:0] trip);
    clamp_warn = (v < trip) ? v : (trip - 16'h0001);
  endfunction

  // ==========================================================
  // level monitors
  logic oc_warn_c;
  logic oc_trip_c;
  logic ov_warn_c;
  logic ov_trip_c;
  logic hs_warn_c;
  logic hs_trip_c;
  logic li_warn_c;
  logic li_trip_c;
  logic sens_bad_c;
  logic [7:0] hs_warn_lvl;
  logic [7:0] li_warn_lvl;

  // [RULE_10] margins below shutdown
  assign hs_warn_lvl = sat_sub8(PSM_HS_TRIP, state_reg.hs_margin);
  assign li_warn_lvl = sat_sub8(PSM_LI_TRIP, state_reg.li_margin);

  // [RULE_04] fixed trip levels
  psm_level_mon #(.W(16)) u_oc (
    .value_i(output_current_i),
    .warn_lvl_i(state_reg.cur_warn),
    .trip_lvl_i(PSM_OC_TRIP),
    .warn_o(oc_warn_c),
    .trip_o(oc_trip_c)
  );

  psm_level_mon #(.W(16)) u_ov (
    .value_i(dc_link_voltage_i),
    .warn_lvl_i(state_reg.vdc_warn),
    .trip_lvl_i(PSM_VDC_TRIP),
    .warn_o(ov_warn_c),
    .trip_o(ov_trip_c)
  );

  // [RULE_06] heatsink always compared
  // [RULE_14] no fan input; fan loss shows as heating
  psm_level_mon #(.W(8)) u_hs (
    .value_i(heatsink_temperature_i),
    .warn_lvl_i(hs_warn_lvl),
    .trip_lvl_i(PSM_HS_TRIP),
    .warn_o(hs_warn_c),
    .trip_o(hs_trip_c)
  );

  // [RULE_07] trip level means above 100
  psm_level_mon #(.W(8)) u_li (
    .value_i(inverter_utilization_i),
    .warn_lvl_i(li_warn_lvl),
    .trip_lvl_i(PSM_LI_TRIP),
    .warn_o(li_warn_c),
    .trip_o(li_trip_c)
  );

  // [RULE_15] open or shorted sensor
  assign sens_bad_c = (temp_sensor_code_i <= PSM_SENS_SHORT) ||
                      (temp_sensor_code_i >= PSM_SENS_OPEN);

  // ==========================================================
  // apb decode
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic fault_ack;

  // one wait state: pready rises in the second access cycle
  assign apb_acc = psel_i && penable_i && state_reg.pready;
  assign apb_wr = apb_acc && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pwrite_i && !state_reg.pready;
  assign addr_ok = (paddr_i <= PSM_MEAS_OFS) && (paddr_i[1:0] == 2'b00);
  assign fault_ack = apb_wr && (paddr_i == PSM_CTRL_OFS) && pwdata_i[PSM_CTRL_ACK_BIT];

  function automatic logic [31:0] read_mux(input psm_state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      PSM_CTRL_OFS: d[PSM_CTRL_SEL_LSB +: 2] = s.resp_sel;
      PSM_CUR_WARN_OFS: d[15:0] = s.cur_warn;
      PSM_VDC_WARN_OFS: d[15:0] = s.vdc_warn;
      PSM_HS_MARGIN_OFS: d[7:0] = s.hs_margin;
      PSM_LI_MARGIN_OFS: d[7:0] = s.li_margin;
      PSM_STATUS_OFS: begin
        d[PSM_ST_OC_WARN] = s.oc_warn;
        d[PSM_ST_OV_WARN] = s.ov_warn;
        d[PSM_ST_HS_WARN] = s.hs_warn;
        d[PSM_ST_LI_WARN] = s.li_warn;
        d[PSM_ST_OC_FAULT] = s.oc_fault;
        d[PSM_ST_OV_FAULT] = s.ov_fault;
        d[PSM_ST_OT_FAULT] = s.ot_fault;
        d[PSM_ST_SENS_FAULT] = s.sens_fault;
        d[PSM_ST_RED_FOUT] = s.red_fout;
        d[PSM_ST_RED_FPULSE] = s.red_fpulse;
        d[PSM_ST_TRIP] = s.trip;
      end
      default: d = 32'h0000_0000;
    endcase
    read_mux = d;
  endfunction

  // ==========================================================
  // next state
  logic thermal_warn;

  always_comb begin
    state_next = state_reg;
    thermal_warn = 1'b0;

    // apb handshake
    state_next.pready = psel_i && penable_i && !state_reg.pready;
    state_next.pslverr = psel_i && penable_i && !state_reg.pready && !addr_ok;
    if (apb_rd) begin
      state_next.prdata = read_mux(state_reg, paddr_i);
      if (paddr_i == PSM_STATUS_OFS) begin
        state_next.prdata[PSM_ST_LI_OVER] = li_trip_c;
      end
      if (paddr_i == PSM_MEAS_OFS) begin
        state_next.prdata[7:0] = heatsink_temperature_i;
        state_next.prdata[PSM_MEAS_UTIL_LSB +: 8] = inverter_utilization_i;
      end
    end

    // [RULE_05] settable warning levels
    if (apb_wr) begin
      case (paddr_i)
        PSM_CTRL_OFS: state_next.resp_sel = pwdata_i[PSM_CTRL_SEL_LSB +: 2];
        PSM_CUR_WARN_OFS: state_next.cur_warn = clamp_warn(pwdata_i[15:0], PSM_OC_TRIP);
        PSM_VDC_WARN_OFS: state_next.vdc_warn = clamp_warn(pwdata_i[15:0], PSM_VDC_TRIP);
        PSM_HS_MARGIN_OFS: state_next.hs_margin = pwdata_i[7:0];
        PSM_LI_MARGIN_OFS: state_next.li_margin = pwdata_i[7:0];
        default: state_next.resp_sel = state_reg.resp_sel;
      endcase
    end

    // [RULE_16] warnings follow the live compare
    // [RULE_09] warning set no later than the fault
    state_next.oc_warn = oc_warn_c || oc_trip_c;
    state_next.ov_warn = ov_warn_c || ov_trip_c;
    state_next.hs_warn = hs_warn_c || hs_trip_c;
    state_next.li_warn = li_warn_c || li_trip_c;

    // [RULE_02] current limiter engaged
    state_next.cur_lim = state_next.oc_warn;
    // [RULE_03] vdc limiter engaged
    state_next.vdc_lim = state_next.ov_warn;

    // [RULE_12] response with the warning
    // [RULE_08] response decode
    thermal_warn = state_next.hs_warn || state_next.li_warn;
    state_next.red_fout = 1'b0;
    state_next.red_fpulse = 1'b0;
    if (thermal_warn) begin
      case (psm_resp_t'(state_reg.resp_sel))
        PSM_RESP_RED_FOUT: state_next.red_fout = 1'b1;
        // [RULE_13] operating point untouched
        PSM_RESP_TRIP_ONLY: state_next.red_fout = 1'b0;
        PSM_RESP_RED_BOTH: begin
          state_next.red_fout = 1'b1;
          state_next.red_fpulse = 1'b1;
        end
        PSM_RESP_RED_FPULSE_TRIP: state_next.red_fpulse = 1'b1;
        default: state_next.red_fout = 1'b0;
      endcase
    end

    // [RULE_16] faults latch; a new trip beats the ack
    // [RULE_01] second level shuts down
    state_next.oc_fault = oc_trip_c || (state_reg.oc_fault && !fault_ack);
    state_next.ov_fault = ov_trip_c || (state_reg.ov_fault && !fault_ack);
    // [RULE_13] thermal trip only at fixed shutdown
    state_next.ot_fault = hs_trip_c || li_trip_c || (state_reg.ot_fault && !fault_ack);
    state_next.sens_fault = sens_bad_c || (state_reg.sens_fault && !fault_ack);
    state_next.trip = state_next.oc_fault || state_next.ov_fault ||
                      state_next.ot_fault || state_next.sens_fault;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
      // [RULE_05] defaults below trip
      state_reg.resp_sel <= PSM_SEL_RST;
      state_reg.cur_warn <= PSM_CUR_WARN_RST;
      state_reg.vdc_warn <= PSM_VDC_WARN_RST;
      // [RULE_11] default 15 degree margin
      state_reg.hs_margin <= PSM_HS_MARGIN_RST;
      state_reg.li_margin <= PSM_LI_MARGIN_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata_o = state_reg.prdata;
  assign pready_o = state_reg.pready;
  assign pslverr_o = state_reg.pslverr;
  assign overcurrent_warning_o = state_reg.oc_warn;
  assign overvoltage_warning_o = state_reg.ov_warn;
  assign heatsink_overtemp_warning_o = state_reg.hs_warn;
  assign load_integral_warning_o = state_reg.li_warn;
  assign overcurrent_fault_o = state_reg.oc_fault;
  assign overvoltage_fault_o = state_reg.ov_fault;
  assign overtemperature_fault_o = state_reg.ot_fault;
  assign sensor_fault_o = state_reg.sens_fault;
  assign current_limit_o = state_reg.cur_lim;
  assign vdc_limit_o = state_reg.vdc_lim;
  assign reduce_output_freq_o = state_reg.red_fout;
  assign reduce_pulse_freq_o = state_reg.red_fpulse;
  assign trip_o = state_reg.trip;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_oc_fault;
    oc_trip_c |=> overcurrent_fault_o && overcurrent_warning_o && current_limit_o;
  endproperty
  a_oc_fault: assert property (p_oc_fault) else $error("overcurrent trip not latched"); // RULE_02

  property p_ov_fault;
    ov_trip_c |=> overvoltage_fault_o && vdc_limit_o ##1 (overvoltage_fault_o || $past(fault_ack));
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("overvoltage fault lost"); // RULE_03

  property p_fault_hold;
    overcurrent_fault_o && !fault_ack && !oc_trip_c |=> overcurrent_fault_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without ack"); // RULE_16

  property p_warn_drop;
    !oc_warn_c && !oc_trip_c |=> !overcurrent_warning_o && !current_limit_o;
  endproperty
  a_warn_drop: assert property (p_warn_drop) else $error("warning not withdrawn"); // RULE_16

  property p_hs_margin;
    (heatsink_temperature_i >= sat_sub8(PSM_HS_TRIP, state_reg.hs_margin))
      |=> heatsink_overtemp_warning_o;
  endproperty
  a_hs_margin: assert property (p_hs_margin) else $error("heatsink warning missed"); // RULE_10

  property p_resp_fout;
    heatsink_overtemp_warning_o && $past(state_reg.resp_sel) == 2'h0
      |-> reduce_output_freq_o && !reduce_pulse_freq_o;
  endproperty
  a_resp_fout: assert property (p_resp_fout) else $error("select 0 response wrong"); // RULE_12

  property p_trip_only;
    $past(state_reg.resp_sel) == 2'h1 |-> !reduce_output_freq_o && !reduce_pulse_freq_o;
  endproperty
  a_trip_only: assert property (p_trip_only) else $error("trip-only changed operating point"); // RULE_13

  property p_li_over;
    (inverter_utilization_i > 8'h64) |=> overtemperature_fault_o && load_integral_warning_o;
  endproperty
  a_li_over: assert property (p_li_over) else $error("utilization overload missed"); // RULE_07

  property p_sensor;
    sens_bad_c |=> sensor_fault_o && trip_o;
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor fault missed"); // RULE_15

  property p_apb_wait;
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong"); // RULE_05
endmodule
`default_nettype wire

// >>> verilog/psm_pkg.sv
`default_nettype none
package psm_pkg;
  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] PSM_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSM_CUR_WARN_OFS = 8'h04;
  localparam logic [7:0] PSM_VDC_WARN_OFS = 8'h08;
  localparam logic [7:0] PSM_HS_MARGIN_OFS = 8'h0c;
  localparam logic [7:0] PSM_LI_MARGIN_OFS = 8'h10;
  localparam logic [7:0] PSM_STATUS_OFS = 8'h14;
  localparam logic [7:0] PSM_MEAS_OFS = 8'h18;

  // ==========================================================
  // field positions
  localparam int PSM_CTRL_SEL_LSB = 0;
  localparam int PSM_CTRL_ACK_BIT = 8;
  localparam int PSM_ST_OC_WARN = 0;
  localparam int PSM_ST_OV_WARN = 1;
  localparam int PSM_ST_HS_WARN = 2;
  localparam int PSM_ST_LI_WARN = 3;
  localparam int PSM_ST_OC_FAULT = 4;
  localparam int PSM_ST_OV_FAULT = 5;
  localparam int PSM_ST_OT_FAULT = 6;
  localparam int PSM_ST_SENS_FAULT = 7;
  localparam int PSM_ST_RED_FOUT = 8;
  localparam int PSM_ST_RED_FPULSE = 9;
  localparam int PSM_ST_TRIP = 10;
  localparam int PSM_ST_LI_OVER = 11;
  localparam int PSM_MEAS_UTIL_LSB = 8;

  // ==========================================================
  // fixed shutdown levels, never writable
  localparam logic [15:0] PSM_OC_TRIP = 16'h0fa0;
  localparam logic [15:0] PSM_VDC_TRIP = 16'h0320;
  localparam logic [7:0] PSM_HS_TRIP = 8'h5f;
  // utilization above 100 percent, i.e. at or above 101
  localparam logic [7:0] PSM_LI_TRIP = 8'h65;
  // sensor codes at or outside these limits mean open or shorted sensor
  localparam logic [11:0] PSM_SENS_SHORT = 12'h010;
  localparam logic [11:0] PSM_SENS_OPEN = 12'hff0;

  // ==========================================================
  // reset values of the user settings
  localparam logic [1:0] PSM_SEL_RST = 2'h0;
  localparam logic [15:0] PSM_CUR_WARN_RST = 16'h0e10;
  localparam logic [15:0] PSM_VDC_WARN_RST = 16'h02ee;
  localparam logic [7:0] PSM_HS_MARGIN_RST = 8'h0f;
  localparam logic [7:0] PSM_LI_MARGIN_RST = 8'h05;

  typedef enum logic [1:0] {
    PSM_RESP_RED_FOUT = 2'h0,
    PSM_RESP_TRIP_ONLY = 2'h1,
    PSM_RESP_RED_BOTH = 2'h2,
    PSM_RESP_RED_FPULSE_TRIP = 2'h3
  } psm_resp_t;
endpackage
`default_nettype wire

// >>> verilog/psm_level_mon.sv
`timescale 1ns/1ps
`default_nettype none
// two-level compare of one monitored quantity
module psm_level_mon #(
  parameter int W = 16
) (
  input wire logic [W-1:0] value_i,
  input wire logic [W-1:0] warn_lvl_i,
  input wire logic [W-1:0] trip_lvl_i,
  output logic warn_o,
  output logic trip_o
);
  // ==========================================================
  // compare
  // both levels compared inclusively; trip level is fixed by caller
  assign warn_o = (value_i >= warn_lvl_i);
  assign trip_o = (value_i >= trip_lvl_i);
endmodule
`default_nettype wire

// >>> tb/psm_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module psm_monitor_bench import psm_pkg::*;;
  // ==========================================================
  // stimulus and wiring
  localparam logic [15:0] NC = 16'h0100;
  localparam logic [15:0] NV = 16'h0200;
  localparam logic [7:0] NH = 8'h20;
  localparam logic [7:0] NU = 8'h32;
  localparam logic [11:0] NS = 12'h800;
  logic mclk, resetn, psel, penable, pwrite;
  logic [7:0] paddr, hs, util;
  logic [31:0] pwdata;
  logic [15:0] cur, vdc;
  logic [11:0] code;
  wire [31:0] prdata;
  wire pready, pslverr, ocw, ovw, hsw, liw, ocf, ovf, otf, senf, clim, vlim, rfo, rfp, trip;
  // low eight bits follow the status register, limits and responses above them
  wire [12:0] outs = {trip, rfp, rfo, vlim, clim, senf, otf, ovf, ocf, liw, hsw, ovw, ocw};
  int fails;
  int checks;

  psm_monitor DUT (.mclk_i(mclk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .output_current_i(cur),
    .dc_link_voltage_i(vdc), .heatsink_temperature_i(hs), .inverter_utilization_i(util),
    .temp_sensor_code_i(code), .overcurrent_warning_o(ocw), .overvoltage_warning_o(ovw),
    .heatsink_overtemp_warning_o(hsw), .load_integral_warning_o(liw),
    .overcurrent_fault_o(ocf), .overvoltage_fault_o(ovf), .overtemperature_fault_o(otf),
    .sensor_fault_o(senf), .current_limit_o(clim), .vdc_limit_o(vlim),
    .reduce_output_freq_o(rfo), .reduce_pulse_freq_o(rfp), .trip_o(trip));

  // ==========================================================
  // shared tasks
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready, read data and error are all taken at the rising edge that sees ready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                      input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
    chk({what, " slverr"}, {31'h0, experr}, {31'h0, e});
  endtask

  task automatic ack(input logic [1:0] s);
    wreg(PSM_CTRL_OFS, {23'h0, 1'b1, 6'h0, s});
  endtask

  // one edge applies the new inputs, the next one samples them and the outputs land on it
  task automatic step(input logic [15:0] c, input logic [15:0] v, input logic [7:0] h,
                      input logic [7:0] u, input logic [11:0] s, input string what,
                      input logic [12:0] exp);
    @(posedge mclk);
    cur <= c;
    vdc <= v;
    hs <= h;
    util <= u;
    code <= s;
    @(posedge mclk);
    @(negedge mclk);
    chk(what, {19'h0, exp}, {19'h0, outs});
  endtask

  function automatic logic [12:0] resp_of(input int i);
    case (i)
      0: return 13'h400;
      1: return 13'h000;
      2: return 13'hc00;
      default: return 13'h800;
    endcase
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rchk("ctrl", PSM_CTRL_OFS, 32'h0, 1'b0);
    rchk("cur warn", PSM_CUR_WARN_OFS, 32'h0e10, 1'b0);
    rchk("vdc warn", PSM_VDC_WARN_OFS, 32'h02ee, 1'b0);
    rchk("hs margin", PSM_HS_MARGIN_OFS, 32'h0f, 1'b0);
    rchk("li margin", PSM_LI_MARGIN_OFS, 32'h05, 1'b0);
    rchk("unmapped", 8'h1c, 32'h0, 1'b1);
    apb(1'b1, 8'h05, 32'h1, r, e);
    chk("unaligned slverr", 32'h1, {31'h0, e});
    wreg(PSM_STATUS_OFS, 32'hfff);
    rchk("status ro", PSM_STATUS_OFS, 32'h0, 1'b0);
    $display("test registers done");
  endtask

  task automatic t_oc;
    step(16'h0e0f, NV, NH, NU, NS, "oc below", 13'h000);
    step(16'h0e10, NV, NH, NU, NS, "oc warn", 13'h101);
    step(16'h0fa0, NV, NH, NU, NS, "oc fault", 13'h1111);
    step(NC, NV, NH, NU, NS, "oc latched", 13'h1010);
    rchk("oc status", PSM_STATUS_OFS, 32'h410, 1'b0);
    ack(2'h0);
    step(NC, NV, NH, NU, NS, "oc acked", 13'h000);
    $display("test overcurrent done");
  endtask

  task automatic t_ov;
    step(NC, 16'h02ed, NH, NU, NS, "ov below", 13'h000);
    step(NC, 16'h02ee, NH, NU, NS, "ov warn", 13'h202);
    step(NC, 16'h0320, NH, NU, NS, "ov fault", 13'h1222);
    ack(2'h0);
    step(NC, 16'h0320, NH, NU, NS, "ov ack held", 13'h1222);
    step(NC, NV, NH, NU, NS, "ov latched", 13'h1020);
    ack(2'h0);
    step(NC, NV, NH, NU, NS, "ov acked", 13'h000);
    $display("test overvoltage done");
  endtask

  task automatic t_thermal;
    logic [12:0] rs;
    for (int i = 0; i < 4; i++) begin
      rs = resp_of(i);
      wreg(PSM_CTRL_OFS, 32'(i));
      step(NC, NV, 8'h4f, NU, NS, "hs below", 13'h000);
      step(NC, NV, 8'h50, NU, NS, "hs warn", 13'h004 | rs);
      step(NC, NV, 8'h5f, NU, NS, "hs trip", 13'h1044 | rs);
      step(NC, NV, NH, NU, NS, "hs latched", 13'h1040);
      ack(2'(i));
    end
    step(NC, NV, 8'h50, NU, NS, "hs meas", 13'h804);
    rchk("meas", PSM_MEAS_OFS, {16'h0, NU, 8'h50}, 1'b0);
    $display("test heatsink done");
  endtask

  task automatic t_util;
    wreg(PSM_CTRL_OFS, 32'h2);
    step(NC, NV, NH, 8'h5f, NS, "li below", 13'h000);
    step(NC, NV, NH, 8'h60, NS, "li warn", 13'hc08);
    step(NC, NV, NH, 8'h64, NS, "li at full", 13'hc08);
    step(NC, NV, NH, 8'h65, NS, "li over", 13'h1c48);
    rchk("li status", PSM_STATUS_OFS, 32'hf48, 1'b0);
    step(NC, NV, NH, NU, NS, "li latched", 13'h1040);
    ack(2'h2);
    step(NC, NV, NH, NU, NS, "li acked", 13'h000);
    $display("test utilization done");
  endtask

  task automatic t_margin;
    wreg(PSM_HS_MARGIN_OFS, 32'h5);
    rchk("hs margin", PSM_HS_MARGIN_OFS, 32'h5, 1'b0);
    step(NC, NV, 8'h59, NU, NS, "hs m below", 13'h000);
    step(NC, NV, 8'h5a, NU, NS, "hs m warn", 13'hc04);
    wreg(PSM_LI_MARGIN_OFS, 32'ha);
    step(NC, NV, NH, 8'h5b, NS, "li m warn", 13'hc08);
    wreg(PSM_CUR_WARN_OFS, 32'hffff);
    rchk("cur clamp", PSM_CUR_WARN_OFS, 32'h0f9f, 1'b0);
    step(16'h0f9f, NV, NH, NU, NS, "oc clamp", 13'h101);
    $display("test margins done");
  endtask

  task automatic t_sensor;
    step(NC, NV, NH, NU, 12'h011, "sens ok", 13'h000);
    step(NC, NV, NH, NU, 12'h010, "sens short", 13'h1080);
    step(NC, NV, NH, NU, NS, "sens latched", 13'h1080);
    ack(2'h2);
    step(NC, NV, NH, NU, 12'hfef, "sens high ok", 13'h000);
    step(NC, NV, NH, NU, 12'hff0, "sens open", 13'h1080);
    $display("test sensor done");
  endtask

  // ==========================================================
  // run control
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (50000) @(posedge mclk);
    fails++;
    $display("[FAIL] run length expected done seen hung");
    stop_test();
  end

  initial begin
    fails = 0;
    checks = 0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cur, vdc, hs, util, code} = {NC, NV, NH, NU, NS};
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("reset outs", 32'h0, {19'h0, outs});
    @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_oc();
    t_ov();
    t_thermal();
    t_util();
    t_margin();
    t_sensor();
    stop_test();
  end
endmodule
`default_nettype wire
